// ---- verif/rtcrc_bus_master.sv ----
`timescale 1ns/1ps
module rtcrc_bus_master #(
    parameter logic [6:0] DEV_ADDR = 7'h50
) (
    // bus pins
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic start();
        if (!scl_o) begin
            #24 sda_pull_o = 1'b0;
            #16 scl_o = 1'b1;
            #40;
        end
        sda_pull_o = 1'b1;
        #40 scl_o = 1'b0;
    endtask
    task automatic stop();
        #24 sda_pull_o = 1'b1;
        #16 scl_o = 1'b1;
        #40 sda_pull_o = 1'b0;
        #40;
    endtask
    // data set mid low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        #24 sda_pull_o = !b;
        #16 scl_o = 1'b1;
        #24 s = sda_i;
        #16 scl_o = 1'b0;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic get(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(!ack, s);
    endtask
    task automatic read_seq(input logic set_ptr, input logic [5:0] a, input int n,
                            output logic [7:0] q[$], output logic ok);
        logic ack;
        logic [7:0] d;
        ok = 1'b1;
        q = {};
        start();
        if (set_ptr) begin
            put({DEV_ADDR, 1'b0}, ack);
            ok &= ack;
            put({2'h0, a}, ack);
            ok &= ack;
            start();
        end
        put({DEV_ADDR, 1'b1}, ack);
        ok &= ack;
        for (int i = 0; i < n; i++) begin
            get(i < n - 1, d);
            q.push_back(d);
        end
        stop();
    endtask
    task automatic write_seq(input logic [5:0] a, input logic [7:0] w[$], output logic ok);
        logic ack;
        start();
        put({DEV_ADDR, 1'b0}, ack);
        ok = ack;
        put({2'h0, a}, ack);
        ok &= ack;
        foreach (w[i]) begin
            put(w[i], ack);
            ok &= ack;
        end
        stop();
    endtask
endmodule

// ---- verif/test_rtcrc_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_rtcrc_top import rtcrc_pkg::*; ;
    localparam int OSC_HALF = 1;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic osc_i = 1'b0;
    logic scl, pull, sda_o, sda_oe, pin_o, pin_oe, sec_pulse;
    logic [5:0] wa;
    wire logic sda_line = !(pull || (sda_oe && !sda_o));
    int err_count = 0;
    int cmp_count = 0;
    int osc_cnt = 0;
    logic [7:0] mem [64];
    logic [7:0] q[$];
    logic [7:0] w[$];
    logic ok;
    int n;
    logic [5:0] a;
    logic [7:0] c;
    logic [7:0] cal0;
    int sec_len = 0;
    logic sec_seen = 1'b0;

    rtcrc_top DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .osc_i(osc_i), .test_or_level_pin_o(pin_o),
        .test_or_level_pin_oe_o(pin_oe), .sec_pulse_o(sec_pulse), .word_address_o(wa));
    rtcrc_bus_master mst (.sda_i(sda_line), .scl_o(scl), .sda_pull_o(pull));

    initial begin
        forever #4 clk_sys_i = !clk_sys_i;
    end
    always @(negedge clk_sys_i) begin
        osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
        if (osc_cnt == OSC_HALF - 1) osc_i <= !osc_i;
    end

    function automatic int ft_half_clk();
        return (int'(FT_HALF_LAST) + 1) * 2 * OSC_HALF;
    endfunction
    function automatic logic exp_pull(input logic [7:0] ctl);
        return !ctl[OUT_LEVEL_BIT];
    endfunction
    // first second after reset, corrected once by the first control write
    function automatic logic sec_len_ok(input logic [7:0] ctl, input int m);
        int t;
        t = (int'(PRESC_LAST) + 1) * (int'(TICK_LAST) + 1);
        if (ctl[CAL_MAG_LSB +: CAL_MAG_W] != 5'h00) t = ctl[CAL_SIGN_BIT] ? t - 128 : t + 256;
        t = t * 2 * OSC_HALF;
        return (m >= t - 2 * OSC_HALF - 4) && (m <= t + 2 * OSC_HALF + 4);
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [5:0] ad, input logic [7:0] d[$]);
        logic k;
        mst.write_seq(ad, d, k);
        `CHK("write ack", 1'b1, k)
        foreach (d[i]) mem[6'(ad + i)] = d[i];
    endtask
    task automatic ft_period(output int m);
        logic p;
        @(negedge clk_sys_i) p = pin_oe;
        for (int k = 0; k < 500 && pin_oe === p; k++) @(negedge clk_sys_i);
        p = pin_oe;
        for (m = 0; m < 500 && pin_oe === p; m++) @(negedge clk_sys_i);
        if (m >= 500) begin
            err_count++;
            wrap_up();
        end
    endtask

    initial begin
        void'($urandom(71217));
        repeat (10) @(negedge clk_sys_i);
        srst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        `CHK("pin oe", 1'b0, pin_oe)
        `CHK("sda oe", 1'b0, sda_oe)
        `CHK("pointer", 6'h00, wa)
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            c = {2'(i), 6'($urandom)};
            if (i == 0) begin
                c[CAL_MAG_LSB] = 1'b1;
                cal0 = c;
            end
            wr(CTRL_ADDR, {c});
            repeat (4) @(negedge clk_sys_i);
            `CHK("pin level", 1'b0, pin_o)
            if (c[FREQ_TEST_BIT]) begin
                ft_period(n);
                `CHK("test half period", ft_half_clk(), n)
            end else begin
                `CHK("pin pull", exp_pull(c), pin_oe)
            end
        end
        $display("test control pin done");
        for (int i = 0; i < 3; i++) begin
            a = 6'h08 + 6'($urandom_range(0, 51));
            w = {8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom)};
            wr(a, w);
            mst.read_seq(1'b1, a, 4, q, ok);
            `CHK("read ack", 1'b1, ok)
            foreach (q[j]) `CHK("read byte", mem[6'(a + j)], q[j])
            `CHK("pointer", 6'(a + 3), wa)
            mst.read_seq(1'b0, 6'h00, 1, q, ok);
            `CHK("current read", mem[6'(a + 3)], q[0])
            `CHK("pointer", 6'(a + 3), wa)
        end
        $display("test sequential read done");
        wr(6'h3E, {8'($urandom), 8'($urandom), 8'($urandom)});
        `CHK("pointer", 6'h01, wa)
        mst.read_seq(1'b1, 6'h3E, 3, q, ok);
        `CHK("read byte", mem[62], q[0])
        `CHK("read byte", mem[63], q[1])
        `CHK("read byte", mem[0], q[2])
        `CHK("pointer", 6'h00, wa)
        $display("test wrap done");
        mst.start();
        mst.put({7'h51, 1'b1}, ok);
        mst.stop();
        `CHK("foreign address ack", 1'b0, ok)
        `CHK("sda oe", 1'b0, sda_oe)
        $display("test refusal done");
        for (int k = 0; k < 70000 && !sec_seen; k++) @(negedge clk_sys_i);
        `CHK("second length ok", 1'b1, sec_len_ok(cal0, sec_len))
        $display("test calibration done");
        wrap_up();
    end
    // clocks from reset release to the first second pulse
    initial begin
        wait (!srst_i);
        for (sec_len = 0; sec_len < 70000 && sec_pulse !== 1'b1; sec_len++) @(negedge clk_sys_i);
        sec_seen = 1'b1;
    end
    initial begin
        #800000;
        err_count++;
        wrap_up();
    end
endmodule

// ---- verilog/rtcrc_pkg.sv ----
package rtcrc_pkg;
    localparam logic [5:0] CTRL_ADDR = 6'h07;
    localparam logic [7:0] CTRL_RST = 8'h80;
    localparam int CAL_MAG_LSB = 0;
    localparam int CAL_MAG_W = 5;
    localparam int CAL_SIGN_BIT = 5;
    localparam int FREQ_TEST_BIT = 6;
    localparam int OUT_LEVEL_BIT = 7;
    localparam logic [7:0] PRESC_LAST = 8'hFF;
    localparam logic [7:0] PRESC_SPLIT = 8'h7F;
    localparam logic [6:0] TICK_LAST = 7'h7F;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [5:0] CAL_WINDOW_MIN = 6'h3E;
    localparam logic [4:0] FT_HALF_LAST = 5'h1F;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b011,
        ST_TX = 3'b010,
        ST_MACK = 3'b110
    } rtcrc_state_t;

    typedef enum logic [1:0] {
        KIND_SLAVE = 2'h0,
        KIND_WORD = 2'h1,
        KIND_DATA = 2'h2
    } rtcrc_kind_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] data;
    } rtcrc_wr_t;
endpackage

// ---- verilog/rtcrc_top.sv ----
`timescale 1ns/1ps
// Contract
// - send byte at pointer; advance on ack
// - next address follows each ack until stop
// - read without address starts at pointer
// - calibrate at divide-by-256 stage only
// - magnitude is low five control bits
// - bit five sign: one adds, zero removes
// - adding speeds up, removing slows down
// - 64-minute cycle, first 62 minutes affected
// - magnitude N corrects first 2N minutes
// - step gives +256 or -512 per cycle
// - test bit makes pin toggle 512 Hz
// - test frequency independent of calibration
// - test bit clear: pin follows level bit
// - pin is open drain
module rtcrc_top import rtcrc_pkg::*; #(
    parameter logic [6:0] SLAVE_ADDR = 7'h50, // arbitrary value
    parameter int BUF_DEPTH = 2
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // oscillator
    input wire logic osc_i,
    // test / level pin
    output logic test_or_level_pin_o,
    output logic test_or_level_pin_oe_o,
    // timekeeping observation
    output logic sec_pulse_o,
    output logic [5:0] word_address_o
);
    if (BUF_DEPTH != 2) begin : g_bad_depth
        $error("rtcrc_top: BUF_DEPTH must be 2");
    end

    // synchronisers
    logic [1:0] scl_sync_ff, sda_sync_ff, osc_sync_ff;
    logic scl_prev_ff, sda_prev_ff, osc_prev_ff;
    always_ff @(posedge clk_sys_i) begin
        scl_sync_ff <= {scl_sync_ff[0], scl_i};
        sda_sync_ff <= {sda_sync_ff[0], sda_i};
        osc_sync_ff <= {osc_sync_ff[0], osc_i};
        scl_prev_ff <= scl_sync_ff[1];
        sda_prev_ff <= sda_sync_ff[1];
        osc_prev_ff <= osc_sync_ff[1];
    end
    wire scl_s = scl_sync_ff[1];
    wire sda_s = sda_sync_ff[1];
    wire scl_rise = scl_s && !scl_prev_ff;
    wire scl_fall = !scl_s && scl_prev_ff;
    wire start_cond = scl_s && scl_prev_ff && !sda_s && sda_prev_ff;
    wire stop_cond = scl_s && scl_prev_ff && sda_s && !sda_prev_ff;
    wire osc_tick = osc_sync_ff[1] && !osc_prev_ff;

    // storage
    logic [7:0] mem [0:63];
    logic [7:0] ctrl_ff;
    logic [5:0] ptr_ff;
    wire [7:0] rd_data_w = (ptr_ff == CTRL_ADDR) ? ctrl_ff : mem[ptr_ff];

    // two-entry write buffer
    rtcrc_wr_t buf_ff [0:1];
    logic buf_wr_ff, buf_rd_ff;
    logic [1:0] buf_cnt_ff;
    logic push_valid;
    rtcrc_wr_t push_data;
    wire push_ready = (buf_cnt_ff != 2'h2);
    wire push = push_valid && push_ready;
    wire pop_valid = (buf_cnt_ff != 2'h0);
    wire pop_ready = !scl_fall;
    wire pop = pop_valid && pop_ready;
    rtcrc_wr_t pop_data;
    assign pop_data = buf_ff[buf_rd_ff];

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            buf_wr_ff <= 1'b0;
            buf_rd_ff <= 1'b0;
            buf_cnt_ff <= 2'h0;
        end else begin
            if (push) begin
                buf_ff[buf_wr_ff] <= push_data;
                buf_wr_ff <= !buf_wr_ff;
            end
            if (pop) begin
                buf_rd_ff <= !buf_rd_ff;
            end
            buf_cnt_ff <= buf_cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (pop) begin
            mem[pop_data.addr] <= pop_data.data;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ctrl_ff <= CTRL_RST;
        end else if (pop && pop_data.addr == CTRL_ADDR) begin
            ctrl_ff <= pop_data.data;
        end
    end

    // bus slave
    rtcrc_state_t st_ff;
    rtcrc_kind_t kind_ff;
    logic [2:0] bit_ff;
    logic [7:0] sh_ff;
    logic rw_ff, sda_oe_ff, sda_o_ff;
    // the scl fall that closes a start carries no bit
    logic skip_ff;
    wire [7:0] rx_byte = sh_ff;
    wire byte_done = (bit_ff == BIT_LAST);
    wire addr_hit = (rx_byte[7:1] == SLAVE_ADDR);

    assign push_valid = scl_fall && st_ff == ST_RX && byte_done && kind_ff == KIND_DATA;
    assign push_data = '{addr: ptr_ff, data: sh_ff};

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_ff <= ST_IDLE;
            kind_ff <= KIND_SLAVE;
            bit_ff <= 3'h0;
            sh_ff <= 8'h00;
            rw_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            sda_o_ff <= 1'b0;
            ptr_ff <= 6'h00;
            skip_ff <= 1'b0;
        end else if (start_cond) begin
            st_ff <= ST_RX;
            kind_ff <= KIND_SLAVE;
            bit_ff <= 3'h0;
            sda_oe_ff <= 1'b0;
            skip_ff <= 1'b1;
        end else if (stop_cond) begin
            st_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else if (scl_rise) begin
            case (st_ff)
                ST_RX: begin
                    sh_ff <= {sh_ff[6:0], sda_s};
                end
                ST_MACK: begin
                    if (!sda_s) begin
                        ptr_ff <= ptr_ff + 6'h01;
                    end else begin
                        st_ff <= ST_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall && skip_ff) begin
            skip_ff <= 1'b0;
        end else if (scl_fall) begin
            case (st_ff)
                ST_RX: begin
                    bit_ff <= bit_ff + 3'h1;
                    if (byte_done) begin
                        case (kind_ff)
                            KIND_SLAVE: begin
                                rw_ff <= rx_byte[0];
                                st_ff <= addr_hit ? ST_ACK : ST_IDLE;
                                sda_oe_ff <= addr_hit;
                                kind_ff <= KIND_WORD;
                            end
                            KIND_WORD: begin
                                ptr_ff <= rx_byte[5:0];
                                st_ff <= ST_ACK;
                                sda_oe_ff <= 1'b1;
                                kind_ff <= KIND_DATA;
                            end
                            default: begin
                                if (push_ready) begin
                                    ptr_ff <= ptr_ff + 6'h01;
                                end
                                st_ff <= push_ready ? ST_ACK : ST_IDLE;
                                sda_oe_ff <= push_ready;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (rw_ff) begin
                        st_ff <= ST_TX;
                        sh_ff <= {rd_data_w[6:0], 1'b0};
                        sda_oe_ff <= !rd_data_w[7];
                        bit_ff <= 3'h1;
                    end else begin
                        st_ff <= ST_RX;
                        sda_oe_ff <= 1'b0;
                        bit_ff <= 3'h0;
                    end
                end
                ST_TX: begin
                    if (bit_ff == 3'h0) begin
                        st_ff <= ST_MACK;
                        sda_oe_ff <= 1'b0;
                    end else begin
                        sda_oe_ff <= !sh_ff[7];
                        sh_ff <= {sh_ff[6:0], 1'b0};
                        bit_ff <= bit_ff + 3'h1;
                    end
                end
                ST_MACK: begin
                    st_ff <= ST_TX;
                    sh_ff <= {rd_data_w[6:0], 1'b0};
                    sda_oe_ff <= !rd_data_w[7];
                    bit_ff <= 3'h1;
                end
                default: begin
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // calibrated divider
    logic [7:0] presc_ff;
    logic [6:0] tick_ff;
    logic [5:0] sec_ff, min_ff;
    logic cal_done_ff, sec_pulse_ff;
    wire [4:0] cal_mag = ctrl_ff[CAL_MAG_LSB +: CAL_MAG_W];
    wire cal_sign = ctrl_ff[CAL_SIGN_BIT];
    wire cal_minute = (min_ff < {cal_mag, 1'b0}) && (min_ff < CAL_WINDOW_MIN);
    wire cal_second = cal_minute && sec_ff == 6'h00 && !cal_done_ff;
    wire split_w = cal_second && cal_sign && presc_ff == PRESC_SPLIT;
    wire blank_w = cal_second && !cal_sign && presc_ff == PRESC_LAST;
    wire tick128 = osc_tick && (split_w || (presc_ff == PRESC_LAST && !blank_w));
    wire sec_wrap = tick128 && tick_ff == TICK_LAST;
    wire min_wrap = sec_wrap && sec_ff == SEC_LAST;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            presc_ff <= 8'h00;
            tick_ff <= 7'h00;
            sec_ff <= 6'h00;
            min_ff <= 6'h00;
            cal_done_ff <= 1'b0;
            sec_pulse_ff <= 1'b0;
        end else begin
            sec_pulse_ff <= sec_wrap;
            if (osc_tick) begin
                presc_ff <= (split_w || presc_ff == PRESC_LAST) ? 8'h00 : presc_ff + 8'h01;
            end
            if (osc_tick && (split_w || blank_w)) begin
                cal_done_ff <= 1'b1;
            end else if (min_wrap) begin
                cal_done_ff <= 1'b0;
            end
            if (tick128) begin
                tick_ff <= tick_ff + 7'h01;
            end
            if (sec_wrap) begin
                sec_ff <= (sec_ff == SEC_LAST) ? 6'h00 : sec_ff + 6'h01;
            end
            if (min_wrap) begin
                min_ff <= min_ff + 6'h01;
            end
        end
    end

    // uncalibrated test square wave and pin
    logic [4:0] ft_cnt_ff;
    logic ft_sq_ff, pin_oe_ff;
    wire freq_test_enable = ctrl_ff[FREQ_TEST_BIT];
    wire output_level_bit = ctrl_ff[OUT_LEVEL_BIT];
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ft_cnt_ff <= 5'h00;
            ft_sq_ff <= 1'b1;
            pin_oe_ff <= 1'b0;
        end else begin
            if (osc_tick) begin
                ft_cnt_ff <= ft_cnt_ff + 5'h01;
                if (ft_cnt_ff == FT_HALF_LAST) begin
                    ft_sq_ff <= !ft_sq_ff;
                end
            end
            pin_oe_ff <= freq_test_enable ? !ft_sq_ff : !output_level_bit;
        end
    end

    assign sda_o = sda_o_ff;
    assign sda_oe_o = sda_oe_ff;
    assign test_or_level_pin_o = sda_o_ff;
    assign test_or_level_pin_oe_o = pin_oe_ff;
    assign sec_pulse_o = sec_pulse_ff;
    assign word_address_o = ptr_ff;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    a_ptr_adv_ack: assert property ((st_ff == ST_MACK && scl_rise && !sda_s && !start_cond && !stop_cond)
        |=> ptr_ff == $past(ptr_ff) + 6'h01) else $error("pointer not advanced on ack");
    a_nack_release: assert property ((st_ff == ST_MACK && scl_rise && sda_s && !start_cond && !stop_cond)
        |=> st_ff == ST_IDLE && !sda_oe_o && ptr_ff == $past(ptr_ff)) else $error("nack not handled");
    a_first_bit: assert property ((st_ff == ST_ACK && rw_ff && scl_fall && !start_cond)
        |=> st_ff == ST_TX && sda_oe_o == !$past(rd_data_w[7])) else $error("wrong first bit");
    a_blank_neg: assert property ((osc_tick && blank_w)
        |=> presc_ff == 8'h00 && tick_ff == $past(tick_ff)) else $error("count not removed");
    a_split_pos: assert property ((osc_tick && split_w)
        |=> presc_ff == 8'h00 && tick_ff == $past(tick_ff) + 7'h01) else $error("count not added");
    a_cal_window: assert property ((split_w || blank_w)
        |-> min_ff < 6'h3E && sec_ff == 6'h00 && min_ff < {cal_mag, 1'b0}) else $error("outside window");
    a_ft_toggle: assert property ((osc_tick && ft_cnt_ff == 5'h1F)
        |=> ft_sq_ff != $past(ft_sq_ff) ##1 (!$past(freq_test_enable) || pin_oe_ff == !$past(ft_sq_ff)))
        else $error("test wave wrong");
    a_level_follow: assert property ((!freq_test_enable && !output_level_bit)
        |=> test_or_level_pin_oe_o) else $error("pin not pulled low");
    a_open_drain: assert property (!test_or_level_pin_o && !sda_o) else $error("pin driven high");
endmodule
